// File: logic/mch_hub.sv
// sync hub: membership, trigger join, command check and ordered distribution
// Behaviour
// - mask bit n selects logical slot n
// - slot index reads back its own index
// - software checks card count before setup
// - unmasked cards excluded, run independently
// - software always masks the hub card
// - hub card is clock master for members
// - member triggers joined, no extra setup
// - each member keeps its own trigger settings
// - any member trigger event starts all
// - run commands checked, then sent in order
// - command word is write only, executes codes
// - code 1h resets card fully
// - code 2h applies config, no start
// - 4h starts, applies first, locks config
// - 8h arms, with start or later
// - 10h forces a trigger event
// - 20h disarms, later triggers ignored
// - 40h halts run, else no effect
// - other settings go straight to cards
// - wait ends when hub card is ready
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module mch_hub #(
  parameter int N        = mch_pkg::MCH_SLOTS,
  parameter int HUB_SLOT = mch_pkg::MCH_HUB_SLOT
) (
  input  wire logic                           clk_in,
  input  wire logic                           arst_n_in,
  mch_link_if.hub                             link,
  input  wire logic [N-1:0]                   card_present_in,
  input  wire logic [N-1:0]                   card_trig_in,
  input  wire logic                           hub_card_ready_in,
  output logic      [N-1:0]                   member_sel_out,
  output logic      [mch_pkg::CMD_BITS-1:0]   member_cmd_out,
  output logic                                clk_master_out,
  output logic      [N-1:0]                   clk_follow_out,
  output logic                                group_trig_out
);
  import mch_pkg::*;

  localparam int SW = (N > 1) ? $clog2(N) : 1;
  localparam logic [N-1:0] HUB_BIT = {{(N-1){1'b0}}, 1'b1} << HUB_SLOT;

  function automatic logic [7:0] count_ones(input logic [N-1:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < N; i++) begin
      c = c + 8'(v[i]);
    end
    return c;
  endfunction

  // pin synchronisers
  logic [N-1:0]          present_s1;
  logic [N-1:0]          present_s2;
  logic [N-1:0]          trig_s1;
  logic [N-1:0]          trig_s2;
  logic                  ready_s1;
  logic                  ready_s2;
  logic                  ready_s3;
  // hub state
  logic [N-1:0]          member_mask;
  logic                  run_active;
  logic                  trig_armed;
  logic                  cfg_dirty;
  logic                  cmd_error;
  logic                  wait_pend;
  logic                  force_now;
  logic [CMD_BITS-1:0]   pend;
  mch_seq_e              state;

  // decode of the link request
  wire                   take        = (state == MCH_IDLE) && link.req && !link.ack;
  wire                   hit_cmd     = (link.addr == OFS_COMMAND_WORD);
  wire                   hit_mask    = (link.addr == OFS_MEMBER_MASK);
  wire                   hit_count   = (link.addr == OFS_CARD_COUNT);
  wire                   hit_status  = (link.addr == OFS_HUB_STATUS);
  wire  [15:0]           slot_off    = link.addr - OFS_SLOT_CARD_INDEX;
  wire                   hit_idx     = (link.addr >= OFS_SLOT_CARD_INDEX) && (slot_off < 16'(N));
  wire  [SW-1:0]         slot        = slot_off[SW-1:0];
  wire                   ready_rise  = ready_s2 && !ready_s3;
  wire  [7:0]            card_count  = count_ones(present_s2);

  // a run needs the hub card and only present cards in the mask
  wire                   setup_ok    = member_mask[HUB_SLOT] &&
                                       ((member_mask & ~present_s2) == '0);
  wire  [CMD_BITS-1:0]   cmd_bits    = link.wdata[CMD_BITS-1:0];
  wire                   setup_bad   = !setup_ok && ((cmd_bits & ~CMD_FULL_RESET) != '0);
  // start applies stale settings first
  wire                   need_apply  = ((cmd_bits & CMD_BEGIN_RUN) != '0) && cfg_dirty;
  wire  [CMD_BITS-1:0]   next_pend   = setup_bad ? (cmd_bits & CMD_FULL_RESET) :
                                       (cmd_bits | (need_apply ? CMD_APPLY_CONFIG : '0));

  // sequencer step selection, lowest code first
  wire  [2:0]            step        = mch_first_cmd(pend);
  wire  [CMD_BITS-1:0]   step_code   = CMD_FULL_RESET << step;
  wire  [CMD_BITS-1:0]   rest        = pend & ~step_code;
  wire                   refused     = ((step == STEP_APPLY) && run_active) ||
                                       ((step == STEP_START) && run_active) ||
                                       ((step == STEP_HALT) && !run_active);

  // read data and access errors
  wire  [31:0]           status_word = {28'h0000000, cmd_error, cfg_dirty, trig_armed,
                                        run_active};
  wire  [31:0]           idx_word    = present_s2[slot] ? 32'(slot) : IDX_NONE;
  wire  [31:0]           read_data   = hit_count  ? 32'(card_count) :
                                       hit_mask   ? 32'(member_mask) :
                                       hit_status ? status_word :
                                       hit_idx    ? idx_word : '0;
  wire                   known       = hit_cmd | hit_mask | hit_count | hit_status | hit_idx;
  wire                   read_only   = hit_count | hit_status | hit_idx;
  wire                   acc_err     = !known || (link.we && read_only) ||
                                       (!link.we && hit_cmd) ||
                                       (link.we && hit_mask && run_active);

  // two flops on every pin before use
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      present_s1 <= '0;
      present_s2 <= '0;
      trig_s1    <= '0;
      trig_s2    <= '0;
      ready_s1   <= 1'b0;
      ready_s2   <= 1'b0;
      ready_s3   <= 1'b0;
    end else begin
      present_s1 <= card_present_in;
      present_s2 <= present_s1;
      trig_s1    <= card_trig_in;
      trig_s2    <= trig_s1;
      ready_s1   <= hub_card_ready_in;
      ready_s2   <= ready_s1;
      ready_s3   <= ready_s2;
    end
  end

  // link answers and the command sequencer
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      link.ack       <= 1'b0;
      link.err       <= 1'b0;
      link.rdata     <= '0;
      member_mask    <= '0;
      run_active     <= 1'b0;
      trig_armed     <= 1'b0;
      cfg_dirty      <= 1'b1;
      cmd_error      <= 1'b0;
      wait_pend      <= 1'b0;
      force_now      <= 1'b0;
      pend           <= '0;
      member_cmd_out <= '0;
      state          <= MCH_IDLE;
    end else begin
      link.ack       <= 1'b0;
      member_cmd_out <= '0;
      force_now      <= 1'b0;
      // the hub card reaching ready ends the run
      if (ready_rise) begin
        run_active <= 1'b0;
      end
      unique case (state)
        MCH_IDLE: begin
          if (take && hit_cmd && link.we) begin
            pend      <= next_pend;
            wait_pend <= link.wdata[CB_WAIT_READY];
            cmd_error <= setup_bad;
            state     <= MCH_EXEC;
          end else if (take) begin
            link.ack   <= 1'b1;
            link.err   <= acc_err;
            link.rdata <= link.we ? '0 : read_data;
            if (link.we && hit_mask && !run_active) begin
              member_mask <= link.wdata[N-1:0];
              cfg_dirty   <= 1'b1;
            end
          end
        end
        MCH_EXEC: begin
          if (pend == '0) begin
            if (wait_pend && run_active) begin
              state <= MCH_WAIT;
            end else begin
              link.ack   <= 1'b1;
              link.err   <= cmd_error;
              link.rdata <= '0;
              state      <= MCH_IDLE;
            end
          end else begin
            pend <= rest;
            if (!refused) begin
              member_cmd_out <= step_code;
            end
            unique case (step)
              STEP_RESET: begin
                run_active <= 1'b0;
                trig_armed <= 1'b0;
                cfg_dirty  <= 1'b1;
              end
              STEP_APPLY: begin
                if (run_active) begin
                  cmd_error <= 1'b1;
                end else begin
                  cfg_dirty <= 1'b0;
                end
              end
              STEP_START: begin
                if (!run_active) begin
                  run_active <= 1'b1;
                  cfg_dirty  <= 1'b0;
                end
              end
              STEP_ARM: begin
                trig_armed <= 1'b1;
              end
              STEP_FORCE: begin
                force_now <= run_active;
              end
              STEP_DISARM: begin
                trig_armed <= 1'b0;
              end
              STEP_HALT: begin
                run_active <= 1'b0;
              end
              default: begin
                pend <= '0;
              end
            endcase
          end
        end
        MCH_WAIT: begin
          // only the hub card is watched, other members may lag
          if (ready_rise || !run_active) begin
            link.ack   <= 1'b1;
            link.err   <= cmd_error;
            link.rdata <= '0;
            state      <= MCH_IDLE;
          end
        end
        default: begin
          state <= MCH_IDLE;
        end
      endcase
    end
  end

  // group trigger, clock roles and member selection
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      group_trig_out <= 1'b0;
      clk_master_out <= 1'b0;
      clk_follow_out <= '0;
      member_sel_out <= '0;
    end else begin
      // masked member events are ORed and pass only while running and armed, each card keeps its own setup
      group_trig_out <= run_active &&
                        (force_now || (trig_armed && |(trig_s2 & member_mask)));
      clk_master_out <= member_mask[HUB_SLOT];
      clk_follow_out <= member_mask & ~HUB_BIT;
      member_sel_out <= member_mask;
    end
  end
endmodule

// File: logic/mch_pkg.sv
// shared constants, types and helpers for the multi-card sync hub and its controller
package mch_pkg;
  // hub geometry
  localparam int MCH_SLOTS    = 16;
  localparam int MCH_HUB_SLOT = 0;
  localparam int LINK_AW      = 16;
  localparam int LINK_DW      = 32;

  // hub register offsets on the link
  localparam logic [15:0] OFS_COMMAND_WORD    = 16'h0064;
  localparam logic [15:0] OFS_MEMBER_MASK     = 16'hC030;
  localparam logic [15:0] OFS_CARD_COUNT      = 16'hBF5E;
  localparam logic [15:0] OFS_SLOT_CARD_INDEX = 16'hBF68;
  localparam logic [15:0] OFS_HUB_STATUS      = 16'hC100;

  // command codes, one bit each, executed lowest bit first
  localparam int CMD_BITS = 7;
  localparam logic [6:0] CMD_FULL_RESET     = 7'h01;
  localparam logic [6:0] CMD_APPLY_CONFIG   = 7'h02;
  localparam logic [6:0] CMD_BEGIN_RUN      = 7'h04;
  localparam logic [6:0] CMD_ARM_TRIGGER    = 7'h08;
  localparam logic [6:0] CMD_FORCE_EVENT    = 7'h10;
  localparam logic [6:0] CMD_DISARM_TRIGGER = 7'h20;
  localparam logic [6:0] CMD_HALT_RUN       = 7'h40;
  localparam int CB_WAIT_READY = 14;

  // step numbers matching the command bit positions
  localparam logic [2:0] STEP_RESET  = 3'h0;
  localparam logic [2:0] STEP_APPLY  = 3'h1;
  localparam logic [2:0] STEP_START  = 3'h2;
  localparam logic [2:0] STEP_ARM    = 3'h3;
  localparam logic [2:0] STEP_FORCE  = 3'h4;
  localparam logic [2:0] STEP_DISARM = 3'h5;
  localparam logic [2:0] STEP_HALT   = 3'h6;

  // hub status word bits
  localparam int ST_RUN   = 0;
  localparam int ST_ARMED = 1;
  localparam int ST_DIRTY = 2;
  localparam int ST_ERROR = 3;
  localparam logic [31:0] IDX_NONE = 32'hFFFF_FFFF;

  // controller register byte addresses on APB
  localparam logic [31:0] HR_LINK_ADDR   = 32'h0000_0000;
  localparam logic [31:0] HR_LINK_WDATA  = 32'h0000_0004;
  localparam logic [31:0] HR_LINK_CTRL   = 32'h0000_0008;
  localparam logic [31:0] HR_LINK_STATUS = 32'h0000_000C;
  localparam logic [31:0] HR_LINK_RDATA  = 32'h0000_0010;
  localparam int HC_GO    = 0;
  localparam int HC_WRITE = 1;
  localparam int HS_BUSY  = 0;
  localparam int HS_ERROR = 1;

  typedef enum logic [1:0] {
    MCH_IDLE = 2'b00,
    MCH_EXEC = 2'b01,
    MCH_WAIT = 2'b10
  } mch_seq_e;

  // lowest pending command bit, which sets the execution order
  function automatic logic [2:0] mch_first_cmd(input logic [CMD_BITS-1:0] p);
    logic [2:0] f;
    f = 3'h0;
    for (int i = CMD_BITS - 1; i >= 0; i--) begin
      if (p[i]) begin
        f = 3'(i);
      end
    end
    return f;
  endfunction
endpackage

// File: logic/mch_link_if.sv
// request/answer link between the hub controller and the sync hub
`timescale 1ns/1ps
interface mch_link_if;
  logic        req;
  logic        we;
  logic [15:0] addr;
  logic [31:0] wdata;
  logic        ack;
  logic        err;
  logic [31:0] rdata;

  modport hub (input req, input we, input addr, input wdata,
               output ack, output err, output rdata);
  modport ctl (output req, output we, output addr, output wdata,
               input ack, input err, input rdata);
endinterface

// File: logic/mch_ctl.sv
// hub controller: APB registers that relay software requests onto the hub link
`timescale 1ns/1ps
module mch_ctl (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  mch_link_if.ctl          link
);
  import mch_pkg::*;

  logic [15:0] link_addr;
  logic [31:0] link_wdata;
  logic        busy;
  logic        last_err;
  logic [31:0] last_rdata;

  // APB decode; one wait state so every answer comes from a flop
  wire         access   = psel_in && penable_in;
  wire         sample   = access && !pready_out;
  wire         commit   = access && pready_out && pwrite_in;
  wire         hit_addr = (paddr_in == HR_LINK_ADDR);
  wire         hit_wdat = (paddr_in == HR_LINK_WDATA);
  wire         hit_ctrl = (paddr_in == HR_LINK_CTRL);
  wire         hit_stat = (paddr_in == HR_LINK_STATUS);
  wire         hit_rdat = (paddr_in == HR_LINK_RDATA);
  wire         known    = hit_addr | hit_wdat | hit_ctrl | hit_stat | hit_rdat;
  // a new request while one is open is refused, not queued
  wire         bad_go   = pwrite_in && hit_ctrl && busy && pwdata_in[HC_GO];
  wire         bad_ro   = pwrite_in && (hit_stat | hit_rdat);
  wire  [31:0] rd_mux   = hit_addr ? 32'(link_addr) :
                          hit_wdat ? link_wdata :
                          hit_stat ? {30'h00000000, last_err, busy} :
                          hit_rdat ? last_rdata : '0;
  wire         launch   = commit && hit_ctrl && !busy && pwdata_in[HC_GO];

  // APB answer
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= '0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= sample;
      prdata_out  <= (sample && !pwrite_in) ? rd_mux : '0;
      pslverr_out <= sample && (!known || bad_go || bad_ro);
    end
  end

  // staging registers and request launch
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      link_addr  <= '0;
      link_wdata <= '0;
      busy       <= 1'b0;
      last_err   <= 1'b0;
      last_rdata <= '0;
      link.req   <= 1'b0;
      link.we    <= 1'b0;
      link.addr  <= '0;
      link.wdata <= '0;
    end else begin
      if (commit && hit_addr) begin
        link_addr <= pwdata_in[15:0];
      end
      if (commit && hit_wdat) begin
        link_wdata <= pwdata_in;
      end
      // any staged address is relayed; the hub refuses card settings and other unknown offsets
      if (launch) begin
        busy       <= 1'b1;
        last_err   <= 1'b0;
        link.req   <= 1'b1;
        link.we    <= pwdata_in[HC_WRITE];
        link.addr  <= link_addr;
        link.wdata <= link_wdata;
      end else if (link.ack && link.req) begin
        busy       <= 1'b0;
        last_err   <= link.err;
        last_rdata <= link.rdata;
        link.req   <= 1'b0;
      end
    end
  end
endmodule

// File: test/mch_link_sva.sv
// checker for the request/answer link between hub controller and sync hub
`timescale 1ns/1ps
module mch_link_sva (
  input wire logic        clk_in,
  input wire logic        arst_n_in,
  input wire logic        req,
  input wire logic        we,
  input wire logic [15:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        ack,
  input wire logic        err,
  input wire logic [31:0] rdata
);
  import mch_pkg::*;

  logic        is_idx;
  logic [15:0] idx_ofs;

  // slot index window decode, sixteen consecutive offsets
  assign idx_ofs = addr - OFS_SLOT_CARD_INDEX;
  assign is_idx  = (addr >= OFS_SLOT_CARD_INDEX) && (idx_ofs < 16'h0010);

  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  a_ack_one_cycle: assert property (ack |=> !ack)
    else $error("link answer longer than one cycle");
  a_ack_needs_req: assert property (ack |-> req)
    else $error("link answer without request");
  a_req_held_stable: assert property (req && !ack |=>
    req && $stable(addr) && $stable(we) && $stable(wdata))
    else $error("link request changed before answer");
  a_req_drop_after: assert property (ack |=> !req)
    else $error("link request not dropped after answer");
  a_reg_answer_fast: assert property ($rose(req) && addr != OFS_COMMAND_WORD |->
    ##[1:2] ack)
    else $error("register access answer late");
  a_cmd_answer_bound: assert property ($rose(req) && we && addr == OFS_COMMAND_WORD
    && !wdata[CB_WAIT_READY] |-> ##[2:12] ack)
    else $error("command answer late");
  a_cmd_read_refused: assert property (ack && !we && addr == OFS_COMMAND_WORD |-> err)
    else $error("command word read not refused");
  a_index_value: assert property (ack && !we && is_idx |->
    rdata == {16'h0000, idx_ofs} || rdata == IDX_NONE)
    else $error("slot index read wrong");
  a_count_range: assert property (ack && !we && addr == OFS_CARD_COUNT |->
    !err && rdata <= 32'(MCH_SLOTS))
    else $error("card count out of range");

  // main scenarios seen on the link
  c_mask_write: cover property (ack && we && addr == OFS_MEMBER_MASK);
  c_cmd_write: cover property (ack && we && addr == OFS_COMMAND_WORD);
  c_refused: cover property (ack && err);
  c_wait_answer: cover property (ack && we && addr == OFS_COMMAND_WORD && wdata[CB_WAIT_READY]);
endmodule

// File: test/multi_card_sync_hub_bench.sv
// bench joining hub controller and sync hub, driven over apb
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module multi_card_sync_hub_bench;
  import mch_pkg::*;
  logic        clk_in = 1'b0, arst_n_in = 1'b0, ready = 1'b0, log_clr = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, r_dat, st;
  logic        pready, pslverr, r_err, grp, mst;
  logic [15:0] present = 16'h0, trig = 16'h0, mask, rnd, sel, follow;
  logic [6:0]  mcmd;
  logic [48:0] cmd_log;
  int          hits, n_fail = 0, compares = 0, seed;
  mch_link_if  link_if();

  always #5 clk_in = ~clk_in;

  mch_ctl mch_ctl_inst(.clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .link(link_if.ctl));
  mch_hub mch_hub_inst(.clk_in(clk_in), .arst_n_in(arst_n_in), .link(link_if.hub),
    .card_present_in(present), .card_trig_in(trig), .hub_card_ready_in(ready),
    .member_sel_out(sel), .member_cmd_out(mcmd), .clk_master_out(mst),
    .clk_follow_out(follow), .group_trig_out(grp));
  mch_link_sva mch_link_sva_inst(.clk_in(clk_in), .arst_n_in(arst_n_in),
    .req(link_if.req), .we(link_if.we), .addr(link_if.addr), .wdata(link_if.wdata),
    .ack(link_if.ack), .err(link_if.err), .rdata(link_if.rdata));

  // broadcast pulses packed oldest first, so order is checked as one value
  always @(posedge clk_in) begin
    if (log_clr) begin
      cmd_log <= '0;
      hits <= 0;
    end else begin
      if (mcmd != 7'h00) cmd_log <= {cmd_log[41:0], mcmd};
      if (grp === 1'b1) hits <= hits + 1;
    end
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // expected readbacks for a cabled pattern
  function automatic logic [31:0] exp_index(input logic [15:0] p, input int n);
    return p[n] ? 32'(n) : IDX_NONE;
  endfunction
  function automatic logic [31:0] exp_count(input logic [15:0] p);
    return 32'($countones(p));
  endfunction

  // one apb transfer; result left in r_dat and r_err
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_fail++;
      stop_test();
    end
    r_dat = prdata;
    r_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic lnk_go(input logic w, input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, HR_LINK_ADDR, {16'h0000, a});
    apb(1'b1, HR_LINK_WDATA, d);
    apb(1'b1, HR_LINK_CTRL, {30'h0, w, 1'b1});
  endtask

  // poll busy under a bound; a hang counts as a mismatch
  task automatic lnk_wait;
    int k;
    k = 0;
    do begin
      apb(1'b0, HR_LINK_STATUS, 32'h0);
      k++;
    end while (r_dat[HS_BUSY] !== 1'b0 && k < 200);
    if (k >= 200) begin
      n_fail++;
      stop_test();
    end
    st = r_dat;
    apb(1'b0, HR_LINK_RDATA, 32'h0);
    r_err = st[HS_ERROR];
  endtask

  task automatic lnk(input logic w, input logic [15:0] a, input logic [31:0] d);
    lnk_go(w, a, d);
    lnk_wait();
  endtask

  task automatic cmd(input logic [31:0] c);
    @(posedge clk_in);
    log_clr <= 1'b1;
    @(posedge clk_in);
    log_clr <= 1'b0;
    lnk(1'b1, OFS_COMMAND_WORD, c);
  endtask

  initial begin
    seed = $urandom(22);
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b1;
    // slot 2 always cabled but never a member, to see outsiders ignored
    rnd = 16'($urandom) | 16'h0007;
    mask = ((16'($urandom) & rnd) | 16'h0003) & 16'hFFFB;
    present <= rnd;
    repeat (4) @(posedge clk_in);
    apb(1'b0, 32'h0000_0020, 32'h0);
    `CHK("unmapped", 1'b1, r_err)
    apb(1'b1, HR_LINK_STATUS, 32'h0000_0001);
    `CHK("status write", 1'b1, r_err)
    lnk(1'b0, OFS_CARD_COUNT, 32'h0);
    `CHK("count", exp_count(rnd), r_dat)
    for (int n = 0; n < 16; n++) begin
      lnk(1'b0, OFS_SLOT_CARD_INDEX + 16'(n), 32'h0);
      `CHK("index", exp_index(rnd, n), r_dat)
    end
    lnk(1'b1, OFS_MEMBER_MASK, {16'h0000, mask & 16'hFFFE});
    cmd(32'h0000_0004);
    `CHK("no hub card err", 1'b1, r_err)
    `CHK("no hub card pulses", 49'h0, cmd_log)
    lnk(1'b1, OFS_MEMBER_MASK, {16'h0000, mask});
    lnk(1'b0, OFS_MEMBER_MASK, 32'h0);
    `CHK("mask", {16'h0000, mask}, r_dat)
    `CHK("members", mask, sel)
    `CHK("master", 1'b1, mst)
    `CHK("followers", mask & 16'hFFFE, follow)
    lnk(1'b0, OFS_COMMAND_WORD, 32'h0);
    `CHK("cmd read", 1'b1, r_err)
    // a card's own setting sent to the hub is refused
    lnk(1'b1, 16'h0100, 32'h0000_0001);
    `CHK("card setting", 1'b1, r_err)
    cmd(32'h0000_000C);
    `CHK("start arm", {28'h0, CMD_APPLY_CONFIG, CMD_BEGIN_RUN, CMD_ARM_TRIGGER}, cmd_log)
    lnk(1'b1, OFS_MEMBER_MASK, 32'h0000_FFFF);
    `CHK("mask locked", 1'b1, r_err)
    cmd(32'h0000_0002);
    `CHK("apply locked", 1'b1, r_err)
    `CHK("apply locked pulses", 49'h0, cmd_log)
    lnk(1'b0, OFS_HUB_STATUS, 32'h0);
    `CHK("running", 1'b1, r_dat[ST_RUN])
    `CHK("armed", 1'b1, r_dat[ST_ARMED])
    trig <= 16'h0004;
    repeat (8) @(posedge clk_in);
    `CHK("outsider trig", 1'b0, grp)
    trig <= mask & 16'hFFFE;
    repeat (8) @(posedge clk_in);
    `CHK("member trig", 1'b1, grp)
    trig <= 16'h0000;
    repeat (8) @(posedge clk_in);
    `CHK("trig gone", 1'b0, grp)
    cmd(32'h0000_0020);
    trig <= 16'h0001;
    repeat (8) @(posedge clk_in);
    `CHK("disarmed", 1'b0, grp)
    trig <= 16'h0000;
    cmd(32'h0000_0010);
    `CHK("forced", 1'b1, hits > 0)
    cmd(32'h0000_0008);
    lnk(1'b0, OFS_HUB_STATUS, 32'h0);
    `CHK("rearmed", 1'b1, r_dat[ST_ARMED])
    cmd(32'h0000_0040);
    `CHK("halt", {42'h0, CMD_HALT_RUN}, cmd_log)
    cmd(32'h0000_0040);
    `CHK("halt idle", 49'h0, cmd_log)
    cmd(32'h0000_0002);
    `CHK("apply", {42'h0, CMD_APPLY_CONFIG}, cmd_log)
    lnk(1'b0, OFS_HUB_STATUS, 32'h0);
    `CHK("apply no run", 1'b0, r_dat[ST_RUN])
    cmd(32'h0000_007F);
    `CHK("all codes", {CMD_FULL_RESET, CMD_APPLY_CONFIG, CMD_BEGIN_RUN, CMD_ARM_TRIGGER,
      CMD_FORCE_EVENT, CMD_DISARM_TRIGGER, CMD_HALT_RUN}, cmd_log)
    // reset in a running, armed group clears run and arm, marks config stale
    cmd(32'h0000_000C);
    cmd(32'h0000_0001);
    `CHK("reset pulse", {42'h0, CMD_FULL_RESET}, cmd_log)
    lnk(1'b0, OFS_HUB_STATUS, 32'h0);
    `CHK("reset state", 4'h4, r_dat[3:0])
    // wait code holds the answer until the hub card reports ready
    lnk_go(1'b1, OFS_COMMAND_WORD, 32'h0000_4004);
    repeat (20) @(posedge clk_in);
    apb(1'b0, HR_LINK_STATUS, 32'h0);
    `CHK("wait busy", 1'b1, r_dat[HS_BUSY])
    apb(1'b1, HR_LINK_CTRL, 32'h0000_0003);
    `CHK("second go", 1'b1, r_err)
    ready <= 1'b1;
    lnk_wait();
    `CHK("wait done", 1'b0, r_err)
    lnk(1'b0, OFS_HUB_STATUS, 32'h0);
    `CHK("run ended", 1'b0, r_dat[ST_RUN])
    ready <= 1'b0;
    stop_test();
  end
endmodule
